// *** hdl/porseq_pkg.sv ***
package porseq_pkg;
	localparam int unsigned SYS_CLK_HZ     = 100_000_000;
	localparam int unsigned STAB_TIME_MS   = 125;
	// least time rounds up to whole cycles
	localparam longint unsigned STAB_CYC_L =
		(longint'(STAB_TIME_MS) * SYS_CLK_HZ + 999) / 1000;
	localparam int unsigned STAB_CYCLES    = int'(STAB_CYC_L);
	localparam int          STAB_W         = 24;
	localparam logic [15:0] RESTART_ADDR   = 16'h0000;
	localparam logic [2:0]  SYNC_RST_VAL   = 3'h0;

	typedef enum {
		PORSEQ_CLEAR,
		PORSEQ_STAB,
		PORSEQ_WAITCY,
		PORSEQ_RUN
	} porseq_state_t;

	// reset bundle seen by the core
	typedef struct packed {
		logic haltEntryReset;
		logic coreResetSignal;
		logic systemReset;
	} porseq_resets_t;
endpackage : porseq_pkg

// *** hdl/porseq_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - clear stops oscillator and all operation
// - clear holds all three internal resets
// - clear release restarts oscillator, frees resets
// - leaving clear enters halt ended by carry
// - halt lasts at least 125 ms, ends on next carry edge
// - core state initialised at clear assertion
// - clear acts regardless of chip-enable level
// - restart from 0000H after forced halt
// - clear in clock stop looks unchanged
// - clock stop clear also restarts at 0000H
// - chip-enable rise after reset restarts again
// - clear sets carry disable, flag read clears
module porseq_top
	import porseq_pkg::*;
#(
	parameter int unsigned STAB_CNT = STAB_CYCLES
) (
	input  wire logic           sys_clk,        // oscillator clock
	input  wire logic           arst_n,         // board reset
	input  wire logic           supplyClearIndication, // async, high = supply low
	input  wire logic           chipEnable,     // async chip-enable pin
	input  wire logic           carrySetPulse,  // base timer carry setting pulse
	input  wire logic           carryFlagRead,  // instruction read the carry flag
	input  wire logic           clockStopReq,   // core in clock stop mode
	output porseq_resets_t      resets,         // active-high reset bundle
	output logic                oscEnable,      // crystal oscillator run
	output logic                haltActive,     // forced halt in progress
	output logic                restartStrobe,  // one-cycle load of restart addr
	output logic [15:0]         restartAddr,    // program start address
	output logic                carryDisable,   // carry disable flip-flop
	output logic                baseTimerCarryFlag // carry flag as seen by core
);
	logic [1:0]    rstSync_r;
	logic          rstN;
	logic [2:0]    clrSync_r;
	logic          clrN;
	logic [2:0]    ceSync_r;
	logic          ceLevel_r;
	logic          cySeen_r;
	porseq_state_t state_r, state_nxt;
	logic [STAB_W-1:0] stabCnt_r;

	// board reset released through two flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) rstSync_r <= 2'h0;
		else rstSync_r <= {rstSync_r[0], 1'h1};
	end
	assign rstN = rstSync_r[1];

	// clear asserts at once, releases through three flops
	wire clrAsyncN = rstN & ~supplyClearIndication;
	always_ff @(posedge sys_clk or negedge clrAsyncN) begin
		if (!clrAsyncN) clrSync_r <= SYNC_RST_VAL;
		else clrSync_r <= {clrSync_r[1:0], 1'h1};
	end
	// a one in flop three means flops two and three agree
	assign clrN = clrSync_r[2];

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) ceSync_r <= SYNC_RST_VAL;
		else ceSync_r <= {ceSync_r[1:0], chipEnable};
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) ceLevel_r <= 1'h0;
		else if (ceSync_r[1] == ceSync_r[2]) ceLevel_r <= ceSync_r[2];
	end
	wire ceRise = (ceSync_r[1] == ceSync_r[2]) & ceSync_r[2] & ~ceLevel_r;

	// carry pulse edge, idle low so no false edge after clear
	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) cySeen_r <= 1'h0;
		else cySeen_r <= carrySetPulse;
	end
	wire cyRise = carrySetPulse & ~cySeen_r;

	wire stabDone = (stabCnt_r >= STAB_W'(STAB_CNT - 1));
	wire ceRestart = (state_r == PORSEQ_RUN) & ceRise;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			PORSEQ_CLEAR:  state_nxt = PORSEQ_STAB;
			PORSEQ_STAB:   if (stabDone) state_nxt = PORSEQ_WAITCY;
			PORSEQ_WAITCY: if (cyRise) state_nxt = PORSEQ_RUN;
			PORSEQ_RUN:    if (ceRestart) state_nxt = PORSEQ_WAITCY;
		endcase
	end

	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) state_r <= PORSEQ_CLEAR;
		else state_r <= state_nxt;
	end

	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) stabCnt_r <= '0;
		else if (state_r == PORSEQ_STAB && !stabDone) stabCnt_r <= stabCnt_r + 1'b1;
	end

	wire inClear = (state_r == PORSEQ_CLEAR);
	wire restartNow = (state_r == PORSEQ_WAITCY) & cyRise;

	// resets and oscillator follow the clear at once, its release one cycle later
	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) begin
			resets        <= '{1'h1, 1'h1, 1'h1};
			oscEnable     <= 1'h0;
			haltActive    <= 1'h1;
			restartStrobe <= 1'h0;
			restartAddr   <= RESTART_ADDR;
		end else begin
			resets        <= '{1'h0, 1'h0, 1'h0};
			oscEnable     <= 1'h1;
			haltActive    <= (state_nxt != PORSEQ_RUN);
			restartStrobe <= restartNow;
			restartAddr   <= RESTART_ADDR;
		end
	end

	// carry disable: set by clear, freed by a flag read
	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) carryDisable <= 1'h1;
		else if (carryFlagRead) carryDisable <= 1'h0;
	end
	always_ff @(posedge sys_clk or negedge clrN) begin
		if (!clrN) baseTimerCarryFlag <= 1'h0;
		else if (cyRise && !carryDisable) baseTimerCarryFlag <= 1'h1;
		else if (carryFlagRead) baseTimerCarryFlag <= 1'h0;
	end

	// sequencer checks
	property p_hold;
		@(posedge sys_clk) disable iff (!rstN)
		!clrN |-> resets.systemReset && !oscEnable;
	endproperty
	a_hold: assert property (p_hold) else $error("resets not held in clear");

	property p_stab;
		@(posedge sys_clk) disable iff (!clrN)
		$rose(state_r == PORSEQ_STAB) |-> haltActive [*8];
	endproperty
	a_stab: assert property (p_stab) else $error("halt ended early");

	property p_restart;
		@(posedge sys_clk) disable iff (!clrN)
		restartNow |=> restartStrobe && restartAddr == RESTART_ADDR && !haltActive;
	endproperty
	a_restart: assert property (p_restart) else $error("restart missing");

	property p_disable;
		@(posedge sys_clk) disable iff (!clrN)
		carryDisable |=> !baseTimerCarryFlag || $past(baseTimerCarryFlag);
	endproperty
	a_disable: assert property (p_disable) else $error("flag set while disabled");

	property p_ce;
		@(posedge sys_clk) disable iff (!clrN)
		ceRestart |=> haltActive;
	endproperty
	a_ce: assert property (p_ce) else $error("chip enable restart missed");

	property p_osc;
		@(posedge sys_clk) disable iff (!rstN)
		$rose(clrN) |=> oscEnable && !resets.haltEntryReset;
	endproperty
	a_osc: assert property (p_osc) else $error("release late");

	property p_clear;
		@(posedge sys_clk) disable iff (!rstN)
		inClear |-> resets == 3'h7 && !oscEnable && haltActive;
	endproperty
	a_clear: assert property (p_clear) else $error("clear state not held");

	property p_stop;
		@(posedge sys_clk) disable iff (!rstN)
		clockStopReq && !clrN |-> !oscEnable && haltActive;
	endproperty
	a_stop: assert property (p_stop) else $error("clock stop clear changed state");

	property p_refuse;
		@(posedge sys_clk) disable iff (!clrN)
		(state_r == PORSEQ_STAB) && cyRise |=> haltActive && !restartStrobe;
	endproperty
	a_refuse: assert property (p_refuse) else $error("carry ended halt too soon");

	property p_strobe;
		@(posedge sys_clk) disable iff (!clrN)
		restartStrobe |=> !restartStrobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("restart strobe too long");

	property p_flagset;
		@(posedge sys_clk) disable iff (!clrN)
		cyRise && !carryDisable |=> baseTimerCarryFlag;
	endproperty
	a_flagset: assert property (p_flagset) else $error("carry flag not set");

	property p_cdis;
		@(posedge sys_clk) disable iff (!clrN)
		carryFlagRead |=> !carryDisable;
	endproperty
	a_cdis: assert property (p_cdis) else $error("carry disable not cleared");

	property p_waitcy;
		@(posedge sys_clk) disable iff (!clrN)
		(state_r == PORSEQ_WAITCY) && !cyRise |=> haltActive;
	endproperty
	a_waitcy: assert property (p_waitcy) else $error("halt ended without carry");

	property p_run;
		@(posedge sys_clk) disable iff (!clrN)
		(state_r == PORSEQ_RUN) |-> !haltActive && resets == 3'h0;
	endproperty
	a_run: assert property (p_run) else $error("run with halt or reset");

	property p_sync;
		@(posedge sys_clk) disable iff (!rstN)
		$rose(clrN) |-> $past(clrAsyncN, 3);
	endproperty
	a_sync: assert property (p_sync) else $error("clear release not synchronised");
endmodule : porseq_top

// *** tb/porseq_supply_model.sv ***
`timescale 1ns/100ps
module porseq_supply_model (
	input  wire logic sys_clk,                      // oscillator clock
	input  wire logic supplyLow,                    // supply under threshold
	input  wire logic ceLevel,                      // chip-enable pin level
	output logic      supplyClearIndication = 1'b1, // detector clear output
	output logic      chipEnable = 1'b0             // chip-enable pin
);
	always @(posedge sys_clk) begin
		supplyClearIndication <= supplyLow;
		chipEnable            <= ceLevel;
	end
endmodule : porseq_supply_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
	import porseq_pkg::*;
	localparam int unsigned SC = 20;
	logic sys_clk = 1'b0, arst_n = 1'b0, supplyLow = 1'b1, ceLevel = 1'b0;
	logic carrySetPulse = 1'b0, carryFlagRead = 1'b0, clockStopReq = 1'b0;
	wire logic sci, ce, osc, halt, strobe, cdis, flag;
	wire logic [15:0] addr;
	porseq_resets_t rst;
	int n_fail = 0, comparisons = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	porseq_supply_model pm (.sys_clk(sys_clk), .supplyLow(supplyLow), .ceLevel(ceLevel),
		.supplyClearIndication(sci), .chipEnable(ce));
	porseq_top #(.STAB_CNT(SC)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
		.supplyClearIndication(sci), .chipEnable(ce), .carrySetPulse(carrySetPulse),
		.carryFlagRead(carryFlagRead), .clockStopReq(clockStopReq), .resets(rst),
		.oscEnable(osc), .haltActive(halt), .restartStrobe(strobe), .restartAddr(addr),
		.carryDisable(cdis), .baseTimerCarryFlag(flag));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic pulse;
		carrySetPulse = 1'b1;
		tick(1);
		carrySetPulse = 1'b0;
		tick(1);
	endtask : pulse
	task automatic restart_check;
		carrySetPulse = 1'b1;
		tick(1);
		carrySetPulse = 1'b0;
		chk(strobe, 1'b1);
		chk(halt, 1'b0);
		chk(addr, RESTART_ADDR);
		tick(1);
		chk(strobe, 1'b0);
	endtask : restart_check
	task automatic power_up;
		chk(rst, 3'h7);
		chk(osc, 1'b0);
		supplyLow = 1'b0;
		tick(6);
		chk(rst, 3'h0);
		chk(osc, 1'b1);
		pulse();
		chk(strobe, 1'b0);
		chk(halt, 1'b1);
		tick(SC + 4);
		chk(halt, 1'b1);
		restart_check();
	endtask : power_up
	task automatic flag_check;
		pulse();
		tick(1);
		chk(flag, 1'b0);
		carryFlagRead = 1'b1;
		tick(1);
		carryFlagRead = 1'b0;
		tick(1);
		chk(cdis, 1'b0);
		pulse();
		tick(1);
		chk(flag, 1'b1);
	endtask : flag_check
	task automatic ce_restart;
		ceLevel = 1'b1;
		tick(8);
		chk(halt, 1'b1);
		restart_check();
	endtask : ce_restart
	task automatic stop_clear;
		clockStopReq = 1'b1;
		supplyLow = 1'b1;
		tick(2);
		chk(rst, 3'h7);
		chk(osc, 1'b0);
		chk(cdis, 1'b1);
		supplyLow = 1'b0;
		tick(SC + 10);
		restart_check();
	endtask : stop_clear
	task automatic close_out;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		tick(3);
		arst_n = 1'b1;
		tick(4);
		power_up();
		flag_check();
		ce_restart();
		stop_clear();
		close_out();
	end
endmodule : tb
